// ==== bench/tb.sv ====
`timescale 1ns/10ps
module tb;
  logic        clk_sys, rstn, cmd1_wr, cmd2_wr, load1_wr, load2_wr, run, hold_lvl, event_input_pin;
  logic [3:0]  cmd1_data, cmd2_data;
  logic [11:0] load_data, first_count, second_count;
  logic        first_overflow, second_overflow, cpu_stall, instr_end;
  int          miscompares, compares, cycles, edges, stalls, instrs;

  tcm_timer dut (.clk_sys(clk_sys), .rstn(rstn), .event_input_pin(event_input_pin),
    .cmd1_wr(cmd1_wr), .cmd1_data(cmd1_data), .cmd2_wr(cmd2_wr), .cmd2_data(cmd2_data),
    .load1_wr(load1_wr), .load2_wr(load2_wr), .load_data(load_data),
    .first_count(first_count), .second_count(second_count), .first_overflow(first_overflow),
    .second_overflow(second_overflow), .cpu_stall(cpu_stall), .instr_end(instr_end));
  tcm_event_src #(.HALF(16)) src (.clk_sys(clk_sys), .run(run), .hold_lvl(hold_lvl), .pin(event_input_pin));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cpu_stall === 1'b1) stalls++;
    if (instr_end === 1'b1) instrs++;
    if (cycles == 60000) begin
      miscompares++;
      close_out();
    end
  end

  always @(posedge event_input_pin) if (run) edges++;

  task automatic close_out;
    if (miscompares == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  task automatic cmp_cnt(input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t count got %h exp %h", $time, got, exp);
    end
  endtask : cmp_cnt

  task automatic ticks(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : ticks

  // Writes both commands and preloads in one cycle
  task automatic setup(input logic [3:0] c1, input logic [3:0] c2, input logic [11:0] v);
    @(negedge clk_sys);
    {cmd1_data, cmd2_data, load_data} = {c1, c2, v};
    {cmd1_wr, cmd2_wr, load1_wr, load2_wr} = 4'hF;
    @(negedge clk_sys);
    {cmd1_wr, cmd2_wr, load1_wr, load2_wr} = 4'h0;
  endtask : setup

  task automatic t_event;
    setup(4'h4, 4'h4, 12'h000);
    edges = 0;
    stalls = 0;
    instrs = 0;
    run = 1'b1;
    ticks(640);
    run = 1'b0;
    ticks(40);
    cmp_cnt(second_count, edges[11:0]);
    cmp_cnt(12'(edges), 12'h014);
    cmp_cnt(stalls[11:0], 12'(8 * edges));
    cmp_cnt(instrs[11:0], 12'h055);
    cmp_cnt(first_count, 12'h000);
  endtask : t_event

  task automatic t_timer;
    int t1, t2;
    t1 = 0;
    t2 = 0;
    // preload one count short of wrap
    setup(4'h8, 4'h8, 12'hFFF);
    for (int i = 0; i < 1200 && t2 == 0; i++) begin
      @(negedge clk_sys);
      if (first_overflow === 1'b1) t1 = cycles;
      if (second_overflow === 1'b1) t2 = cycles;
    end
    cmp_cnt(12'(t2 - t1), 12'h008);
    cmp_cnt(first_count, 12'h000);
    ticks(992);
    cmp_cnt(first_count, 12'h000);
    ticks(40);
    cmp_cnt(first_count, 12'h001);
    cmp_cnt(second_count, 12'h001);
  endtask : t_timer

  task automatic t_pwidth;
    setup(4'hC, 4'hC, 12'h000);
    ticks(2100);
    cmp_cnt(second_count, 12'h000);
    hold_lvl = 1'b1;
    ticks(4096);
    hold_lvl = 1'b0;
    ticks(40);
    cmp_cnt(second_count, 12'h004);
    cmp_cnt(first_count, 12'h000);
    setup(4'h0, 4'h0, 12'h000);
    ticks(1100);
    cmp_cnt(first_count, 12'h000);
    cmp_cnt(second_count, 12'h000);
  endtask : t_pwidth

  // Slower rates: the second rate is timed, the two slowest only shown idle
  task automatic t_rates;
    int n;
    n = 0;
    setup(4'h9, 4'hA, 12'h000);
    while (first_count == 12'h000 && n < 17000) begin
      @(negedge clk_sys);
      n++;
    end
    cmp_cnt(second_count, 12'h000);
    setup(4'h9, 4'hB, 12'h001);
    ticks(16352);
    cmp_cnt(first_count, 12'h001);
    ticks(40);
    cmp_cnt(first_count, 12'h002);
    cmp_cnt(second_count, 12'h001);
  endtask : t_rates

  initial begin
    {rstn, cmd1_wr, cmd2_wr, load1_wr, load2_wr, run, hold_lvl} = 7'h00;
    {cmd1_data, cmd2_data, load_data} = 20'h00000;
    ticks(20);
    rstn = 1'b1;
    ticks(4);
    t_event();
    t_timer();
    t_pwidth();
    t_rates();
    close_out();
  end
endmodule : tb

// ==== bench/tcm_event_src.sv ====
`timescale 1ns/10ps
module tcm_event_src #(
  parameter int HALF = 16
) (
  input  wire logic clk_sys,
  input  wire logic run,
  input  wire logic hold_lvl,
  output logic      pin
);
  int   cnt_r;
  logic run_r;
  logic lvl_r;
  // Controls taken on the rising edge so the pin moves on the falling one
  always_ff @(posedge clk_sys) begin
    run_r <= run;
    lvl_r <= hold_lvl;
  end
  always_ff @(negedge clk_sys) begin
    if (!run_r) begin
      cnt_r <= 0;
      pin   <= lvl_r;
    end else if (cnt_r == HALF - 1) begin
      cnt_r <= 0;
      pin   <= ~pin;
    end else begin
      cnt_r <= cnt_r + 1;
    end
  end
endmodule : tcm_event_src

// ==== design/tcm_consts.svh ====
`ifndef TCM_CONSTS_SVH
`define TCM_CONSTS_SVH

// Command word layout and reset value
`define TCM_CMD_RST        4'h0
`define TCM_CMD_MODE_HI    3
`define TCM_CMD_MODE_LO    2
`define TCM_CMD_RATE_HI    1
`define TCM_CMD_RATE_LO    0

// Count register
`define TCM_CNT_RST        12'h000
`define TCM_CNT_MAX        12'hFFF
`define TCM_CNT_ONE        12'h001

// Instruction cycle is eight base clocks
`define TCM_PHASE_RST      3'h0
`define TCM_PHASE_LAST     3'h7
`define TCM_PHASE_ONE      3'h1
`define TCM_INSTR_CLKS     8

// Internal rates: base clock over 2^(10 + 4*i)
`define TCM_RATE_BASE_BIT  9
`define TCM_RATE_STEP      4
`define TCM_DIV_W          22

`endif

// ==== design/tcm_pkg.sv ====
package tcm_pkg;

  // Order fixes the command codes 00, 01, 10, 11
  typedef enum logic [1:0] {
    TCM_MODE_STOP,
    TCM_MODE_EVENT,
    TCM_MODE_TIMER,
    TCM_MODE_PWIDTH
  } tcm_mode_t;

  typedef enum logic {
    TCM_RUN,
    TCM_STEAL
  } tcm_cpu_t;

endpackage : tcm_pkg

// ==== design/tcm_prescaler.sv ====
`timescale 1ns/10ps
`include "tcm_consts.svh"

module tcm_prescaler #(
  parameter int DIV_W  = `TCM_DIV_W,
  parameter int NRATES = 4
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_n_s,
  output logic      [NRATES-1:0] rate_tick
);

  logic [DIV_W-1:0]  div_r;
  logic [NRATES-1:0] tap_prev_r;

  // Free running; never cleared by commands
  always_ff @(posedge clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NRATES; gi++) begin : g_rate
      localparam int TAP = `TCM_RATE_BASE_BIT + `TCM_RATE_STEP * gi;
      always_ff @(posedge clk_sys or negedge rst_n_s) begin
        if (!rst_n_s) begin
          tap_prev_r[gi] <= 1'b0;
          rate_tick[gi]  <= 1'b0;
        end else begin
          tap_prev_r[gi] <= div_r[TAP];
          // Rising edge of the divided pulse
          rate_tick[gi]  <= div_r[TAP] & ~tap_prev_r[gi];
        end
      end
    end
  endgenerate

endmodule : tcm_prescaler

// ==== design/tcm_timer.sv ====
`timescale 1ns/10ps
`include "tcm_consts.svh"

// Behaviour
// (RQ1) Event mode: count each rising edge of the event input pin.
// (RQ2) External source toggles no faster than base clock over 32.
// (RQ3) At highest event rate, one stolen cycle per four instruction cycles.
// (RQ4) Timer mode: count rising edges of the selected internal pulse.
// (RQ5) Four internal rates selected by the command rate field.
// (RQ6) Fastest rate, base clock over 1024, steals one per 128 cycles.
// (RQ7) Software preloads 4096 minus interval times rate, then awaits overflow.
// (RQ8) Pulse width mode: sample the input with the selected internal rate.
// (RQ9) Pulse width mode: count only while input high, hold while low.
// (RQ10) Measured signal should change much slower than the sampling rate.
// (RQ11) Overflow pulse when count wraps FFF to 000; counting continues.
// (RQ12) Counting starts at first count pulse edge after a command write.
// (RQ13) Each count steals one instruction cycle, stalling instruction and interrupts.
// (RQ14) Simultaneous requests: first counter served, second next instruction cycle.
// (RQ15) Event input synchronised before edge detection or level sampling.
module tcm_timer (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        event_input_pin,
  input  wire logic        cmd1_wr,
  input  wire logic [3:0]  cmd1_data,
  input  wire logic        cmd2_wr,
  input  wire logic [3:0]  cmd2_data,
  input  wire logic        load1_wr,
  input  wire logic        load2_wr,
  input  wire logic [11:0] load_data,
  output logic      [11:0] first_count,
  output logic      [11:0] second_count,
  output logic             first_overflow,
  output logic             second_overflow,
  output logic             cpu_stall,
  output logic             instr_end
);

  logic [1:0]  rst_sync_r;
  logic        rst_n_s;
  logic [3:0]  rate_tick;
  logic [3:0]  cmd1_r;
  logic [3:0]  cmd2_r;
  logic [2:0]  ev_sync_r;
  logic        ev_level;
  logic        ev_rise;
  logic        tick1;
  logic        tick2;
  logic        pulse1;
  logic        pulse2;
  logic        req1_r;
  logic        req2_r;
  logic        serve1;
  logic        serve2;
  logic [2:0]  phase_r;
  logic        boundary;
  tcm_pkg::tcm_mode_t mode1;
  tcm_pkg::tcm_mode_t mode2;
  tcm_pkg::tcm_cpu_t  cpu_r;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n_s = rst_sync_r[1];

  tcm_prescaler u_prescaler (
    .clk_sys   (clk_sys),
    .rst_n_s   (rst_n_s),
    .rate_tick (rate_tick)
  );

  always_ff @(posedge clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      cmd1_r <= `TCM_CMD_RST;
      cmd2_r <= `TCM_CMD_RST;
    end else begin
      if (cmd1_wr) begin
        cmd1_r <= cmd1_data;
      end
      if (cmd2_wr) begin
        cmd2_r <= cmd2_data;
      end
    end
  end

  assign mode1 = tcm_pkg::tcm_mode_t'(cmd1_r[`TCM_CMD_MODE_HI:`TCM_CMD_MODE_LO]);
  assign mode2 = tcm_pkg::tcm_mode_t'(cmd2_r[`TCM_CMD_MODE_HI:`TCM_CMD_MODE_LO]);
  // (RQ5) Rate field select
  assign tick1 = rate_tick[cmd1_r[`TCM_CMD_RATE_HI:`TCM_CMD_RATE_LO]];
  assign tick2 = rate_tick[cmd2_r[`TCM_CMD_RATE_HI:`TCM_CMD_RATE_LO]];

  // (RQ15) Two-flop sync, third for edge
  always_ff @(posedge clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      ev_sync_r <= 3'h0;
    end else begin
      ev_sync_r <= {ev_sync_r[1:0], event_input_pin};
    end
  end
  assign ev_level = ev_sync_r[1];
  assign ev_rise  = ev_sync_r[1] & ~ev_sync_r[2];

  // (RQ4) First counter is timer only; other codes stop it
  assign pulse1 = (mode1 == tcm_pkg::TCM_MODE_TIMER) & tick1;

  always_comb begin
    pulse2 = 1'b0;
    unique case (mode2)
      tcm_pkg::TCM_MODE_STOP:   pulse2 = 1'b0;
      // (RQ1) Pin edge counts
      tcm_pkg::TCM_MODE_EVENT:  pulse2 = ev_rise;
      // (RQ4) Internal pulse counts
      tcm_pkg::TCM_MODE_TIMER:  pulse2 = tick2;
      // (RQ8) (RQ9) Sampled level gates tick
      tcm_pkg::TCM_MODE_PWIDTH: pulse2 = tick2 & ev_level;
    endcase
  end

  // Instruction cycle phase
  always_ff @(posedge clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      phase_r <= `TCM_PHASE_RST;
    end else begin
      phase_r <= phase_r + `TCM_PHASE_ONE;
    end
  end
  assign boundary  = (phase_r == `TCM_PHASE_LAST);
  assign instr_end = boundary;

  // (RQ14) First counter has priority
  assign serve1 = boundary & req1_r;
  assign serve2 = boundary & req2_r & ~req1_r;

  // (RQ12) Write discards stale request; new pulse wins
  always_ff @(posedge clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      req1_r <= 1'b0;
      req2_r <= 1'b0;
    end else begin
      if (pulse1) begin
        req1_r <= 1'b1;
      end else if (serve1 || cmd1_wr) begin
        req1_r <= 1'b0;
      end
      if (pulse2) begin
        req2_r <= 1'b1;
      end else if (serve2 || cmd2_wr) begin
        req2_r <= 1'b0;
      end
    end
  end

  // (RQ13) (RQ3) (RQ6) One stolen instruction cycle per count
  always_ff @(posedge clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      cpu_r <= tcm_pkg::TCM_RUN;
    end else if (boundary) begin
      cpu_r <= (serve1 || serve2) ? tcm_pkg::TCM_STEAL : tcm_pkg::TCM_RUN;
    end
  end
  assign cpu_stall = (cpu_r == tcm_pkg::TCM_STEAL);

  // (RQ11) Wrap pulses overflow and keeps counting
  always_ff @(posedge clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      first_count     <= `TCM_CNT_RST;
      first_overflow  <= 1'b0;
    end else begin
      first_overflow <= serve1 & ~load1_wr & (first_count == `TCM_CNT_MAX);
      if (load1_wr) begin
        first_count <= load_data;
      end else if (serve1) begin
        first_count <= first_count + `TCM_CNT_ONE;
      end
    end
  end

  // (RQ11) Same for second counter
  always_ff @(posedge clk_sys or negedge rst_n_s) begin
    if (!rst_n_s) begin
      second_count    <= `TCM_CNT_RST;
      second_overflow <= 1'b0;
    end else begin
      second_overflow <= serve2 & ~load2_wr & (second_count == `TCM_CNT_MAX);
      if (load2_wr) begin
        second_count <= load_data;
      end else if (serve2) begin
        second_count <= second_count + `TCM_CNT_ONE;
      end
    end
  end

  sequence s_serve1;
    boundary && req1_r && !load1_wr;
  endsequence

  sequence s_steal_cycle;
    cpu_stall [*8];
  endsequence

  property p_event_req;
    @(posedge clk_sys) disable iff (!rst_n_s)
      (mode2 == tcm_pkg::TCM_MODE_EVENT) && ev_rise |=> req2_r;
  endproperty
  a_event_req: assert property (p_event_req) else $error("edge not requested"); // RQ1

  property p_rise_once;
    @(posedge clk_sys) disable iff (!rst_n_s)
      ev_rise |=> !ev_rise;
  endproperty
  a_rise_once: assert property (p_rise_once) else $error("edge seen twice"); // RQ15

  property p_timer_req;
    @(posedge clk_sys) disable iff (!rst_n_s)
      (mode1 == tcm_pkg::TCM_MODE_TIMER) && tick1 |=> req1_r;
  endproperty
  a_timer_req: assert property (p_timer_req) else $error("tick not requested"); // RQ4

  property p_steal;
    @(posedge clk_sys) disable iff (!rst_n_s)
      boundary && (req1_r || req2_r) |=> s_steal_cycle;
  endproperty
  a_steal: assert property (p_steal) else $error("stolen cycle not eight clocks"); // RQ13

  property p_priority;
    @(posedge clk_sys) disable iff (!rst_n_s)
      s_serve1 ##0 req2_r && !cmd2_wr |=> req2_r && first_count == $past(first_count) + `TCM_CNT_ONE;
  endproperty
  a_priority: assert property (p_priority) else $error("priority wrong"); // RQ14

  property p_wrap;
    @(posedge clk_sys) disable iff (!rst_n_s)
      s_serve1 ##0 first_count == `TCM_CNT_MAX |=> first_count == `TCM_CNT_RST && first_overflow;
  endproperty
  a_wrap: assert property (p_wrap) else $error("overflow missed"); // RQ11

  property p_pw_hold;
    @(posedge clk_sys) disable iff (!rst_n_s)
      (mode2 == tcm_pkg::TCM_MODE_PWIDTH) && !ev_level && !req2_r |=> !req2_r;
  endproperty
  a_pw_hold: assert property (p_pw_hold) else $error("counted while low"); // RQ9

  property p_pw_count;
    @(posedge clk_sys) disable iff (!rst_n_s)
      (mode2 == tcm_pkg::TCM_MODE_PWIDTH) && tick2 && ev_level |=> req2_r;
  endproperty
  a_pw_count: assert property (p_pw_count) else $error("high sample not counted"); // RQ8

  property p_cmd_clear;
    @(posedge clk_sys) disable iff (!rst_n_s)
      cmd2_wr && !pulse2 && !serve2 |=> !req2_r;
  endproperty
  a_cmd_clear: assert property (p_cmd_clear) else $error("stale request kept"); // RQ12

  property p_stall_phase;
    @(posedge clk_sys) disable iff (!rst_n_s)
      $rose(cpu_stall) |-> $past(boundary) && phase_r == `TCM_PHASE_RST;
  endproperty
  a_stall_phase: assert property (p_stall_phase) else $error("stall off boundary"); // RQ3

endmodule : tcm_timer
